//--- rwc_core.sv
// Sub-second and seconds counting with periodic watch error correction
module rwc_core
  import rwc_pkg::*;
// Function
// (R01) Interval select 0: correct only at seconds 00, 20 and 40.
// (R02) Interval select 1: correct only at second 00.
// (R03) New direction and magnitude take effect at the next correction point only.
// (R04) Uncorrected seconds last exactly 32,768 sub-second cycles.
// (R05) Direction 0, magnitude 010101, select 0: lengthen by 40 at 00/20/40.
// (R06) Direction 0, magnitude 000010: add 2 cycles at each correction point.
// (R07) Direction 0, magnitude 111111: add 124 cycles at each correction point.
// (R08) Direction 1, magnitude 000010: subtract 124 cycles at each correction point.
// (R09) Direction 1, magnitude all ones: subtract 2 cycles at each correction point.
// (R10) Select 1 uses the same increments, once per 60 seconds.
// (R11) Select 1 uses the same decrements, once per 60 seconds.
// (R12) Increment amount is (magnitude minus one) times two.
// (R13) Decrement amount is (inverted magnitude plus one) times two.
// (R14) Magnitude 000000 or 000001 gives no correction.
// (R15) Sub-second counter wraps after corrected count, then carries into seconds.
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic sub_tick,
  input wire rwc_cfg_t watch_correction_register,
  input wire rwc_load_t counter_load,
  output logic [SUB_W-1:0] subsecond_counter,
  output logic [SEC_W-1:0] seconds_counter,
  output logic second_carry
);

  // ****************************************
  // Decoding helpers
  // ****************************************

  // Correction point test for a given seconds value
  function automatic logic rwc_point(input logic [SEC_W-1:0] sec, input logic sel);
    logic hit;
    hit = (sec == SEC_PT0);
    if (!sel)
    begin
      hit = hit || (sec == SEC_PT20) || (sec == SEC_PT40);
    end
    return hit;
  endfunction

  // Last sub-second count of a corrected second
  function automatic logic [SUB_W-1:0] rwc_last(input rwc_cfg_t c);
    logic [AMT_W-1:0] amt;
    amt = '0;
    // (R14) Small magnitudes do nothing
    if (c.correction_magnitude > MAG_NONE_MAX)
    begin
      if (!c.correction_direction)
      begin
        // (R12) Increment amount formula
        amt = {c.correction_magnitude - MAG_ONE, 1'b0};
      end
      else
      begin
        // (R13) Decrement amount formula
        amt = {(~c.correction_magnitude) + MAG_ONE, 1'b0};
      end
    end
    return c.correction_direction ? (NOM_LAST - {9'h000, amt}) : (NOM_LAST + {9'h000, amt});
  endfunction

  // ****************************************
  // Counter state
  // ****************************************
  logic [SUB_W-1:0] sub_q, sub_d;
  logic [SEC_W-1:0] sec_q, sec_d;
  logic [SUB_W-1:0] last_q, last_d;
  logic carry_q, carry_d;
  logic wrap;
  logic point_next;

  // Next values of the counters and of the current second's length
  always_comb
  begin
    sub_d = sub_q;
    sec_d = sec_q;
    last_d = last_q;
    carry_d = 1'b0;
    wrap = sub_tick && !counter_load.load_en && (sub_q == last_q);
    point_next = 1'b0;
    // Preset wins over counting; the length in force stays untouched,
    // so a preset mid-second never reopens the choice of correction.
    // Limitation: a preset above the current last count runs round 16 bits.
    if (counter_load.load_en)
    begin
      sub_d = counter_load.load_sub;
      sec_d = counter_load.load_sec;
    end
    else if (sub_tick)
    begin
      if (wrap)
      begin
        // (R15) Wrap at corrected length, then carry
        sub_d = SUB_RST;
        carry_d = 1'b1;
        sec_d = (sec_q == SEC_LAST) ? SEC_RST : sec_q + 6'h01;
        // (R01) (R02) Choose correction points by interval select
        point_next = rwc_point(sec_d, watch_correction_register.correction_interval_select);
        // (R03) Setting sampled only as a new second starts
        // (R04) Other seconds run the nominal length
        // (R05) (R06) (R07) (R08) (R09) (R10) (R11) Amount mapping in rwc_last
        last_d = point_next ? rwc_last(watch_correction_register) : NOM_LAST;
      end
      else
      begin
        sub_d = sub_q + 16'h0001;
      end
    end
  end

  // Registering; the length register lets a change mid-second wait safely
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      sub_q <= SUB_RST;
      sec_q <= SEC_RST;
      last_q <= NOM_LAST;
      carry_q <= 1'b0;
    end
    else
    begin
      sub_q <= sub_d;
      sec_q <= sec_d;
      last_q <= last_d;
      carry_q <= carry_d;
    end
  end

  // ****************************************
  // Outputs straight from flip-flops
  // ****************************************
  assign subsecond_counter = sub_q;
  assign seconds_counter = sec_q;
  assign second_carry = carry_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // Helper: setting magnitude, direction and interval select this cycle
  logic [5:0] mag;
  logic dir;
  logic sel;
  assign mag = watch_correction_register.correction_magnitude;
  assign dir = watch_correction_register.correction_direction;
  assign sel = watch_correction_register.correction_interval_select;

  // (R01) Select 0 skips other seconds
  a_sel0_points: assert property (wrap && !sel && sec_d != SEC_PT0 && sec_d != SEC_PT20 && sec_d != SEC_PT40 // (R01)
    |=> last_q == NOM_LAST)
    else $error("correction outside 00/20/40 with select 0");

  // (R01) Select 0 corrects at 20 and 40
  a_sel0_hits: assert property (wrap && !sel && (sec_d == SEC_PT20 || sec_d == SEC_PT40) && mag > MAG_NONE_MAX // (R01)
    |=> last_q != NOM_LAST)
    else $error("no correction at 20 or 40 with select 0");

  // (R02) Select 1 skips all but 00
  a_sel1_points: assert property (wrap && sel && sec_d != SEC_PT0 // (R02)
    |=> last_q == NOM_LAST)
    else $error("correction outside 00 with select 1");

  // (R03) Length fixed between wraps
  a_hold_length: assert property (!wrap // (R03)
    |=> $stable(last_q))
    else $error("second length changed mid-second");

  // (R03) Preset keeps the length
  a_load_len: assert property (counter_load.load_en // (R03)
    |=> $stable(last_q))
    else $error("preset changed the second length");

  // (R04) Plain step of one; the edge of reset release is left out
  a_count_step: assert property (!sys_rst && sub_tick && !counter_load.load_en && sub_q != last_q // (R04)
    |=> sub_q == $past(sub_q) + 16'h0001 && !second_carry)
    else $error("sub-second counter did not step by one");

  // (R15) Wrap clears and pulses carry
  a_wrap_carry: assert property (wrap // (R15)
    |=> sub_q == SUB_RST && second_carry ##1 !second_carry)
    else $error("wrap did not clear counter and pulse carry");

  // (R15) Carry only after a wrap
  a_carry_only: assert property (!wrap // (R15)
    |=> !second_carry)
    else $error("carry without a wrap");

  // (R15) Preset lands without carry
  a_load_takes: assert property (counter_load.load_en // (R15)
    |=> sub_q == $past(counter_load.load_sub) && sec_q == $past(counter_load.load_sec) && !second_carry)
    else $error("preset not taken");

  // (R12) Increment amount formula
  a_inc_amount: assert property (wrap && point_next && !dir && mag > MAG_NONE_MAX // (R12)
    |=> int'(last_q) == int'(NOM_LAST) + (int'($past(mag)) - 1) * 2)
    else $error("increment amount wrong");

  // (R13) Decrement amount formula
  a_dec_amount: assert property (wrap && point_next && dir && mag > MAG_NONE_MAX // (R13)
    |=> int'(last_q) == int'(NOM_LAST) - (int'(6'(~$past(mag))) + 1) * 2)
    else $error("decrement amount wrong");

  // (R05) Mid setting lengthens by 40
  a_inc_example: assert property (wrap && point_next && !dir && mag == 6'h15 // (R05)
    |=> int'(last_q) == int'(NOM_LAST) + AMT_EX)
    else $error("example increment wrong");

  // (R06) Smallest increment
  a_inc_min: assert property (wrap && point_next && !dir && mag == 6'h02 // (R06)
    |=> int'(last_q) == int'(NOM_LAST) + AMT_MIN)
    else $error("smallest increment wrong");

  // (R07) Largest increment
  a_inc_max: assert property (wrap && point_next && !dir && mag == 6'h3F // (R07)
    |=> int'(last_q) == int'(NOM_LAST) + AMT_MAX)
    else $error("largest increment wrong");

  // (R08) Largest decrement
  a_dec_max: assert property (wrap && point_next && dir && mag == 6'h02 // (R08)
    |=> int'(last_q) == int'(NOM_LAST) - AMT_MAX)
    else $error("largest decrement wrong");

  // (R09) Smallest decrement
  a_dec_min: assert property (wrap && point_next && dir && mag == 6'h3F // (R09)
    |=> int'(last_q) == int'(NOM_LAST) - AMT_MIN)
    else $error("smallest decrement wrong");

  // (R10) Select 1 lengthens at 00
  a_sel1_inc: assert property (wrap && sel && sec_d == SEC_PT0 && !dir && mag > MAG_NONE_MAX // (R10)
    |=> last_q > NOM_LAST)
    else $error("no increment at 00 with select 1");

  // (R11) Select 1 shortens at 00
  a_sel1_dec: assert property (wrap && sel && sec_d == SEC_PT0 && dir && mag > MAG_NONE_MAX // (R11)
    |=> last_q < NOM_LAST)
    else $error("no decrement at 00 with select 1");

  // (R14) Small magnitudes ignored
  a_no_corr: assert property (wrap && mag <= MAG_NONE_MAX // (R14)
    |=> last_q == NOM_LAST)
    else $error("small magnitude corrected");

  // (R15) Seconds roll over after 59
  a_sec_wrap: assert property (wrap && sec_q == SEC_LAST // (R15)
    |=> sec_q == SEC_RST)
    else $error("seconds did not wrap after 59");

  // (R15) Seconds step by one
  a_sec_step: assert property (wrap && sec_q != SEC_LAST // (R15)
    |=> sec_q == $past(sec_q) + 6'h01)
    else $error("seconds did not step by one");

endmodule

//--- rwc_pkg.sv
// Shared constants and types for the watch error correction counter
package rwc_pkg;

  // ****************************************
  // Counter widths and limits
  // ****************************************
  localparam int SUB_W = 16;
  localparam int SEC_W = 6;
  localparam int AMT_W = 7;
  // Nominal second is 32,768 sub-second cycles, counted 0000H to 7FFFH
  localparam logic [SUB_W-1:0] NOM_LAST = 16'h7FFF;
  localparam logic [SEC_W-1:0] SEC_LAST = 6'h3B;
  localparam logic [SEC_W-1:0] SEC_PT0 = 6'h00;
  localparam logic [SEC_W-1:0] SEC_PT20 = 6'h14;
  localparam logic [SEC_W-1:0] SEC_PT40 = 6'h28;
  // Magnitudes at or below this value give no correction
  localparam logic [5:0] MAG_NONE_MAX = 6'h01;
  localparam logic [5:0] MAG_ONE = 6'h01;
  // Correction amounts at both ends of the range and for a mid setting
  localparam int AMT_MIN = 2;
  localparam int AMT_MAX = 124;
  localparam int AMT_EX = 40;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [SUB_W-1:0] SUB_RST = 16'h0000;
  localparam logic [SEC_W-1:0] SEC_RST = 6'h00;
  // Preset point near the end of a second, and nominal ticks from there to the wrap
  localparam logic [SUB_W-1:0] SUB_NEAR_END = 16'h7F00;
  localparam int NEAR_TICKS = 256;

  // ****************************************
  // Correction setting as held by the correction register
  // ****************************************
  typedef struct packed {
    logic correction_interval_select;
    logic correction_direction;
    logic [5:0] correction_magnitude;
  } rwc_cfg_t;

  // Counter preset, as a rewrite of the seconds counter would do
  typedef struct packed {
    logic load_en;
    logic [SEC_W-1:0] load_sec;
    logic [SUB_W-1:0] load_sub;
  } rwc_load_t;

endpackage

//--- test_rtc_watch_error_correction.sv
// Self-checking bench for the watch error correction counter
module test_rtc_watch_error_correction;
  timeunit 1ns;
  timeprecision 1ps;
  import rwc_pkg::*;
  logic core_clk;
  logic sys_rst;
  logic sub_tick;
  rwc_cfg_t cfg;
  rwc_load_t ld;
  logic [SUB_W-1:0] sub_cnt;
  logic [SEC_W-1:0] sec_cnt;
  logic second_carry;
  int mismatches;
  int cmp_count;

  rwc_core dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sub_tick(sub_tick),
    .watch_correction_register(cfg),
    .counter_load(ld),
    .subsecond_counter(sub_cnt),
    .seconds_counter(sec_cnt),
    .second_carry(second_carry)
  );

  // ****************************************
  // Clock and shared tasks
  // ****************************************
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // New setting, applied one edge after the call
  task automatic set_cfg(input rwc_cfg_t c);
    @(posedge core_clk);
    cfg <= c;
  endtask

  // Preset near the end of a second; a full second would cost 32,768 cycles each
  task automatic preset(input logic [5:0] sec);
    @(posedge core_clk);
    ld <= '{1'b1, sec, SUB_NEAR_END};
    @(posedge core_clk);
    ld <= '{1'b0, 6'h00, 16'h0000};
  endtask

  // Presets second sec, counts edges up to the carry, then checks the pulse ends
  task automatic step(input logic [5:0] sec, input int exp_ticks);
    int n;
    n = -1;
    preset(sec);
    do
    begin
      @(negedge core_clk);
      n++;
    end while (second_carry !== 1'b1 && n < 1000);
    // A missing carry would hang the run, so it ends here
    if (n >= 1000)
    begin
      mismatches++;
      finish_test();
    end
    else
    begin
      chk(32'(n), 32'(exp_ticks));
      chk({26'h0000000, sec_cnt}, {26'h0000000, ((sec == SEC_LAST) ? SEC_RST : 6'(sec + 6'h01))});
      chk({16'h0000, sub_cnt}, 32'h00000000);
      @(negedge core_clk);
      chk({31'h00000000, second_carry}, 32'h00000000);
    end
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  // Ordinary second away from any point
  task automatic test_nominal();
    step(6'h05, NEAR_TICKS);
  endtask

  // Lengthening at 20 and 40; a change during second 20 waits for the next point
  task automatic test_increment();
    set_cfg('{1'b0, 1'b0, 6'h3F});
    step(6'h13, NEAR_TICKS);
    set_cfg('{1'b0, 1'b0, 6'h02});
    step(6'h14, NEAR_TICKS + AMT_MAX);
    step(6'h27, NEAR_TICKS);
    step(6'h28, NEAR_TICKS + AMT_MIN);
    set_cfg('{1'b0, 1'b0, 6'h15});
    step(6'h13, NEAR_TICKS);
    step(6'h14, NEAR_TICKS + AMT_EX);
  endtask

  // Shortening at 40 and at 00
  task automatic test_decrement();
    set_cfg('{1'b0, 1'b1, 6'h02});
    step(6'h27, NEAR_TICKS);
    step(6'h28, NEAR_TICKS - AMT_MAX);
    set_cfg('{1'b0, 1'b1, 6'h3F});
    step(6'h3B, NEAR_TICKS);
    step(6'h00, NEAR_TICKS - AMT_MIN);
  endtask

  // Select 1: nothing at 20, correction at 00 only
  task automatic test_interval_one();
    set_cfg('{1'b1, 1'b0, 6'h02});
    step(6'h13, NEAR_TICKS);
    step(6'h14, NEAR_TICKS);
    step(6'h3B, NEAR_TICKS);
    step(6'h00, NEAR_TICKS + AMT_MIN);
    set_cfg('{1'b1, 1'b1, 6'h02});
    step(6'h3B, NEAR_TICKS);
    step(6'h00, NEAR_TICKS - AMT_MAX);
  endtask

  // Magnitudes 0 and 1 give nominal seconds at points
  task automatic test_no_correction();
    set_cfg('{1'b0, 1'b0, 6'h01});
    step(6'h3B, NEAR_TICKS);
    step(6'h00, NEAR_TICKS);
    set_cfg('{1'b0, 1'b1, 6'h00});
    step(6'h13, NEAR_TICKS);
    step(6'h14, NEAR_TICKS);
  endtask

  // Reset inside a corrected second restores the nominal length
  task automatic test_mid_reset();
    set_cfg('{1'b0, 1'b0, 6'h3F});
    step(6'h13, NEAR_TICKS);
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk({9'h000, second_carry, sec_cnt, sub_cnt}, 32'h00000000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    step(6'h14, NEAR_TICKS);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    sys_rst = 1'b1;
    sub_tick = 1'b1;
    cfg = '{1'b0, 1'b0, 6'h3F};
    ld = '{1'b0, 6'h00, 16'h0000};
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    chk({9'h000, second_carry, sec_cnt, sub_cnt}, 32'h00000000);
    @(posedge core_clk);
    sys_rst <= 1'b0;
    test_nominal();
    test_increment();
    test_decrement();
    test_interval_one();
    test_no_correction();
    test_mid_reset();
    finish_test();
  end
endmodule
